// ### logic/frc_fault_restart.sv
// Added by the designer: the address map and the address-and-strobe port.
`timescale 1ns/1ps
module frc_fault_restart #(
  parameter logic [26:0] SEC_CYC      = 27'(frc_pkg::SEC_NS / frc_pkg::CLK_PERIOD_NS),
  parameter logic [27:0] KEY_HOLD_CYC =
    28'(frc_pkg::KEY_HOLD_MS * 1_000_000 / frc_pkg::CLK_PERIOD_NS)
) (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  // register port
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  // drive conditions
  input  wire logic        fault_cause,
  input  wire logic        run_permit,
  input  wire logic        io_profile,
  input  wire logic        ext_fitted,
  // clear sources and keys
  input  wire logic [5:0]  local_di,
  input  wire logic [5:0]  ext_di,
  input  wire logic [15:0] fb_cmd,
  input  wire logic        key_stop_reset,
  input  wire logic        key_ok,
  // outputs
  output logic             op_fault,
  output logic             fault_relay,
  output logic             run_enable,
  output logic             reinit_pulse,
  output logic             irq
);
  // interrupt vector width
  localparam int IRQW = frc_pkg::IRQ_W;

  frc_pkg::frc_state_type state_r, state_nxt;
  logic [12:0]  ctrl_r, ctrl_nxt;
  logic         req_r, req_nxt;
  logic [IRQW-1:0] ist_r, ist_nxt, ien_r, ien_nxt;
  logic [26:0]  tick_cnt_r, tick_cnt_nxt;
  logic [5:0]   wait_s_r, wait_s_nxt;
  logic [13:0]  win_s_r, win_s_nxt;
  logic [1:0]   att_r, att_nxt;
  logic [27:0]  key_cnt_r, key_cnt_nxt;
  logic [7:0]   rein_cnt_r, rein_cnt_nxt;
  logic         clr_prev_r, clr_prev_nxt;
  logic         key_prev_r, key_prev_nxt;
  logic [31:0]  rdata_r, rdata_nxt;

  logic        auto_en;
  logic [2:0]  win_sel;
  logic [1:0]  src_sel;
  logic [3:0]  src_idx;
  logic        expert;
  logic        clr_level;
  logic        clear_evt;
  logic        tick;
  logic        locked;
  logic [5:0]  wait_lim;
  logic [IRQW-1:0] ev;

  // selected fault clear level
  function automatic logic clear_src(input logic [1:0] sel, input logic [3:0] idx,
                                     input logic [5:0] ldi, input logic [5:0] edi,
                                     input logic [15:0] fb, input logic ext_ok,
                                     input logic iop);
    logic v;
    v = 1'b0;
    unique case (frc_pkg::frc_src_type'(sel))
      frc_pkg::SRC_NONE:  v = 1'b0;
      frc_pkg::SRC_LOCAL: v = (idx >= 4'h1 && idx <= 4'h6) ? ldi[3'(idx - 4'h1)] : 1'b0;
      frc_pkg::SRC_EXT:   v = (ext_ok && idx >= 4'h1 && idx <= 4'h6) ?
                              edi[3'(idx - 4'h1)] : 1'b0;
      frc_pkg::SRC_FB:    v = (idx == 4'h0) ? 1'b0 :
                              (idx <= 4'ha && !iop) ? 1'b0 : fb[idx];
    endcase
    return v;
  endfunction : clear_src

  // window length in seconds
  function automatic logic [13:0] win_limit(input logic [2:0] sel);
    logic [13:0] v;
    v = frc_pkg::WIN_5M_S;
    case (sel)
      3'h1:    v = frc_pkg::WIN_10M_S;
      3'h2:    v = frc_pkg::WIN_30M_S;
      3'h3:    v = frc_pkg::WIN_1H_S;
      3'h4:    v = frc_pkg::WIN_2H_S;
      3'h5:    v = frc_pkg::WIN_3H_S;
      default: v = frc_pkg::WIN_5M_S;
    endcase
    return v;
  endfunction : win_limit

  assign auto_en   = ctrl_r[frc_pkg::CTRL_AUTO_BIT];
  assign win_sel   = ctrl_r[frc_pkg::CTRL_WIN_LSB +: 3];
  assign src_sel   = ctrl_r[frc_pkg::CTRL_SRC_LSB +: 2];
  assign src_idx   = ctrl_r[frc_pkg::CTRL_IDX_LSB +: 4];
  assign expert    = ctrl_r[frc_pkg::CTRL_EXPERT_BIT];
  assign clr_level = clear_src(src_sel, src_idx, local_di, ext_di, fb_cmd,
                               ext_fitted, io_profile);
  // rising edge of source or key, only with the cause gone
  assign clear_evt = ((clr_level && !clr_prev_r) || (key_stop_reset && !key_prev_r))
                     && !fault_cause;
  assign tick      = (tick_cnt_r == SEC_CYC - 27'h000_0001);
  assign locked    = (state_r == frc_pkg::ST_LOCKED) || (state_r == frc_pkg::ST_FAULT);
  assign wait_lim  = (att_r == 2'h0) ? frc_pkg::WAIT1_S :
                     (att_r == 2'h1) ? frc_pkg::WAIT2_S :
                     (att_r == 2'h2) ? frc_pkg::WAIT3_S : frc_pkg::WAITN_S;

  always_comb begin
    state_nxt    = state_r;
    ctrl_nxt     = ctrl_r;
    req_nxt      = req_r;
    ien_nxt      = ien_r;
    tick_cnt_nxt = tick ? 27'h000_0000 : tick_cnt_r + 27'h000_0001;
    wait_s_nxt   = wait_s_r;
    win_s_nxt    = win_s_r;
    att_nxt      = att_r;
    key_cnt_nxt  = key_cnt_r;
    rein_cnt_nxt = rein_cnt_r;
    clr_prev_nxt = clr_level;
    key_prev_nxt = key_stop_reset;
    rdata_nxt    = 32'h0000_0000;
    ev           = '0;

    // register writes
    if (wr) begin
      unique case (addr)
        frc_pkg::ADDR_CTRL: begin
          ctrl_nxt[frc_pkg::CTRL_AUTO_BIT]   = wdata[frc_pkg::CTRL_AUTO_BIT];
          ctrl_nxt[frc_pkg::CTRL_SRC_LSB +: 2] = wdata[frc_pkg::CTRL_SRC_LSB +: 2];
          ctrl_nxt[frc_pkg::CTRL_IDX_LSB +: 4] = wdata[frc_pkg::CTRL_IDX_LSB +: 4];
          ctrl_nxt[frc_pkg::CTRL_EXPERT_BIT] = wdata[frc_pkg::CTRL_EXPERT_BIT];
          // window writable only with auto retry on; illegal codes ignored
          if (auto_en && wdata[frc_pkg::CTRL_WIN_LSB +: 3] != 3'h7) begin
            ctrl_nxt[frc_pkg::CTRL_WIN_LSB +: 3] = wdata[frc_pkg::CTRL_WIN_LSB +: 3];
          end
        end
        frc_pkg::ADDR_RESTART: begin
          if (expert) begin
            req_nxt = wdata[0];
          end
        end
        frc_pkg::ADDR_IRQ_EN: ien_nxt = wdata[IRQW-1:0];
        default: ;
      endcase
    end

    // confirm key held with request selected
    if (req_r && key_ok) begin
      if (key_cnt_r != KEY_HOLD_CYC) begin
        key_cnt_nxt = key_cnt_r + 28'h000_0001;
      end
    end else begin
      key_cnt_nxt = 28'h000_0000;
    end

    unique case (state_r)
      frc_pkg::ST_RUN: begin
        if (fault_cause) begin
          ev[frc_pkg::IRQ_FAULT] = 1'b1;
          wait_s_nxt   = 6'h00;
          win_s_nxt    = 14'h0000;
          att_nxt      = 2'h0;
          tick_cnt_nxt = 27'h000_0000;
          state_nxt    = auto_en ? frc_pkg::ST_RETRY : frc_pkg::ST_FAULT;
        end
      end
      frc_pkg::ST_RETRY: begin
        if (clear_evt) begin
          state_nxt = frc_pkg::ST_RUN;
          ev[frc_pkg::IRQ_RECOVER] = 1'b1;
        end else if (!auto_en) begin
          state_nxt = frc_pkg::ST_FAULT;
        end else if (tick) begin
          win_s_nxt  = win_s_r + 14'h0001;
          wait_s_nxt = wait_s_r + 6'h01;
          if (wait_s_r + 6'h01 >= wait_lim) begin
            ev[frc_pkg::IRQ_ATTEMPT] = 1'b1;
            wait_s_nxt = 6'h00;
            if (!fault_cause && run_permit) begin
              state_nxt = frc_pkg::ST_RUN;
              ev[frc_pkg::IRQ_RECOVER] = 1'b1;
            end else if (att_r != 2'h3) begin
              att_nxt = att_r + 2'h1;
            end
          end
          if (state_nxt == frc_pkg::ST_RETRY && win_sel != 3'(frc_pkg::WIN_UNL) &&
              win_s_r + 14'h0001 >= win_limit(win_sel)) begin
            state_nxt = frc_pkg::ST_LOCKED;
            ev[frc_pkg::IRQ_LOCK] = 1'b1;
          end
        end
      end
      frc_pkg::ST_FAULT: begin
        if (clear_evt) begin
          state_nxt = frc_pkg::ST_RUN;
          ev[frc_pkg::IRQ_RECOVER] = 1'b1;
        end
      end
      frc_pkg::ST_LOCKED: ;
      frc_pkg::ST_REINIT: begin
        rein_cnt_nxt = rein_cnt_r + 8'h01;
        if (rein_cnt_r == 8'(frc_pkg::REINIT_CYC - 1)) begin
          state_nxt = frc_pkg::ST_RUN;
          req_nxt   = 1'b0;
          ev[frc_pkg::IRQ_REINIT] = 1'b1;
        end
      end
    endcase

    // reinit trigger, ignored unless locked or in fault
    if (key_cnt_r == KEY_HOLD_CYC - 28'h000_0001 && req_r && key_ok && locked) begin
      state_nxt    = frc_pkg::ST_REINIT;
      rein_cnt_nxt = 8'h00;
      att_nxt      = 2'h0;
      wait_s_nxt   = 6'h00;
      win_s_nxt    = 14'h0000;
    end

    // register reads
    if (rd) begin
      unique case (addr)
        frc_pkg::ADDR_CTRL: begin
          rdata_nxt[12:0] = ctrl_r;
          if (!auto_en) begin
            rdata_nxt[frc_pkg::CTRL_WIN_LSB +: 3] = 3'h0;
          end
          if (!expert) begin
            rdata_nxt[frc_pkg::CTRL_EXPERT_BIT] = 1'b0;
          end
        end
        frc_pkg::ADDR_RESTART: rdata_nxt[0] = req_r & expert;
        frc_pkg::ADDR_STATUS: begin
          rdata_nxt[frc_pkg::STAT_STATE_LSB +: 3] = state_r;
          rdata_nxt[frc_pkg::STAT_ATT_LSB +: 2]   = att_r;
          rdata_nxt[frc_pkg::STAT_OPF_BIT]        = op_fault;
          rdata_nxt[frc_pkg::STAT_RELAY_BIT]      = fault_relay;
          rdata_nxt[frc_pkg::STAT_WIN_LSB +: 14]  = win_s_r;
        end
        frc_pkg::ADDR_IRQ_STAT: rdata_nxt[IRQW-1:0] = ist_r;
        frc_pkg::ADDR_IRQ_EN:   rdata_nxt[IRQW-1:0] = ien_r;
        default: ;
      endcase
    end

    // sticky events, set wins over clear
    ist_nxt = ist_r;
    if (wr && addr == frc_pkg::ADDR_IRQ_CLR) begin
      ist_nxt = ist_r & ~wdata[IRQW-1:0];
    end
    ist_nxt = ist_nxt | ev;
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_r    <= frc_pkg::ST_RUN;
      ctrl_r     <= frc_pkg::CTRL_RST;
      req_r      <= 1'b0;
      ist_r      <= '0;
      ien_r      <= '0;
      tick_cnt_r <= 27'h000_0000;
      wait_s_r   <= 6'h00;
      win_s_r    <= 14'h0000;
      att_r      <= 2'h0;
      key_cnt_r  <= 28'h000_0000;
      rein_cnt_r <= 8'h00;
      clr_prev_r <= 1'b0;
      key_prev_r <= 1'b0;
      rdata_r    <= 32'h0000_0000;
    end else begin
      state_r    <= state_nxt;
      ctrl_r     <= ctrl_nxt;
      req_r      <= req_nxt;
      ist_r      <= ist_nxt;
      ien_r      <= ien_nxt;
      tick_cnt_r <= tick_cnt_nxt;
      wait_s_r   <= wait_s_nxt;
      win_s_r    <= win_s_nxt;
      att_r      <= att_nxt;
      key_cnt_r  <= key_cnt_nxt;
      rein_cnt_r <= rein_cnt_nxt;
      clr_prev_r <= clr_prev_nxt;
      key_prev_r <= key_prev_nxt;
      rdata_r    <= rdata_nxt;
    end
  end

  assign rdata        = rdata_r;
  // fault output stays low during retries
  assign op_fault     = locked;
  // relay stays energised through retries
  assign fault_relay  = auto_en || (state_r == frc_pkg::ST_RUN);
  // run allowed only in the healthy state
  assign run_enable   = (state_r == frc_pkg::ST_RUN);
  assign reinit_pulse = (state_r == frc_pkg::ST_REINIT);
  // level interrupt from enabled sticky bits
  assign irq          = |(ist_r & ien_r);
endmodule : frc_fault_restart

// ### logic/frc_pkg.sv
package frc_pkg;
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int SEC_NS        = 1_000_000_000;
  localparam int KEY_HOLD_MS   = 2000;
  localparam int REINIT_NS     = 1000;
  localparam int REINIT_CYC    = (REINIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [5:0] WAIT1_S = 6'h01;
  localparam logic [5:0] WAIT2_S = 6'h05;
  localparam logic [5:0] WAIT3_S = 6'h0a;
  localparam logic [5:0] WAITN_S = 6'h3c;
  // retry window lengths in seconds
  localparam logic [13:0] WIN_5M_S  = 14'h012c;
  localparam logic [13:0] WIN_10M_S = 14'h0258;
  localparam logic [13:0] WIN_30M_S = 14'h0708;
  localparam logic [13:0] WIN_1H_S  = 14'h0e10;
  localparam logic [13:0] WIN_2H_S  = 14'h1c20;
  localparam logic [13:0] WIN_3H_S  = 14'h2a30;
  // register offsets
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_RESTART  = 8'h04;
  localparam logic [7:0] ADDR_STATUS   = 8'h08;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_CLR  = 8'h10;
  localparam logic [7:0] ADDR_IRQ_EN   = 8'h14;
  // control fields
  localparam int CTRL_AUTO_BIT   = 0;
  localparam int CTRL_WIN_LSB    = 1;
  localparam int CTRL_SRC_LSB    = 4;
  localparam int CTRL_IDX_LSB    = 8;
  localparam int CTRL_EXPERT_BIT = 12;
  localparam logic [12:0] CTRL_RST = 13'h0000;
  // status fields
  localparam int STAT_STATE_LSB  = 0;
  localparam int STAT_ATT_LSB    = 4;
  localparam int STAT_OPF_BIT    = 6;
  localparam int STAT_RELAY_BIT  = 7;
  localparam int STAT_WIN_LSB    = 16;
  // interrupt bits
  localparam int IRQ_W       = 5;
  localparam int IRQ_FAULT   = 0;
  localparam int IRQ_ATTEMPT = 1;
  localparam int IRQ_LOCK    = 2;
  localparam int IRQ_RECOVER = 3;
  localparam int IRQ_REINIT  = 4;

  typedef enum logic [2:0] {
    WIN_5M, WIN_10M, WIN_30M, WIN_1H, WIN_2H, WIN_3H, WIN_UNL
  } frc_win_type;

  typedef enum logic [1:0] {
    SRC_NONE, SRC_LOCAL, SRC_EXT, SRC_FB
  } frc_src_type;

  typedef enum logic [2:0] {
    ST_RUN, ST_FAULT, ST_RETRY, ST_LOCKED, ST_REINIT
  } frc_state_type;
endpackage : frc_pkg

// ### tb/frc_props.sv
`timescale 1ns/1ps
module frc_props (
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        rstn,
  // register port
  input wire logic [7:0]  addr,
  input wire logic [31:0] wdata,
  input wire logic        wr,
  // sources
  input wire logic        fault_cause,
  input wire logic [5:0]  local_di,
  input wire logic [5:0]  ext_di,
  input wire logic [15:0] fb_cmd,
  input wire logic        key_stop_reset,
  // outputs
  input wire logic        op_fault,
  input wire logic        fault_relay,
  input wire logic        run_enable,
  input wire logic        reinit_pulse
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  logic       auto_r, auto_nxt;
  logic [7:0] rcnt_r, rcnt_nxt;
  // auto bit shadow, dropped on reinit so it never overclaims
  always_comb begin
    auto_nxt = reinit_pulse ? 1'b0 : auto_r;
    if (wr && addr == frc_pkg::ADDR_CTRL) auto_nxt = wdata[frc_pkg::CTRL_AUTO_BIT];
    rcnt_nxt = reinit_pulse ? rcnt_r + 8'h01 : 8'h00;
  end
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      auto_r <= 1'b0;
      rcnt_r <= 8'h00;
    end else begin
      auto_r <= auto_nxt;
      rcnt_r <= rcnt_nxt;
    end
  end
  chk_relay_auto: assert property (auto_r |-> fault_relay)
    else $error("relay dropped with auto retry on");
  chk_retry_quiet: assert property (run_enable && fault_cause && auto_r
    |=> !op_fault && !run_enable) else $error("fault output raised on retry entry");
  chk_opf_run: assert property (op_fault |-> !run_enable)
    else $error("fault output while running");
  chk_no_restart: assert property (fault_cause && !run_enable
    && !reinit_pulse |=> !run_enable) else $error("restart with cause present");
  chk_fault_entry: assert property (run_enable && fault_cause |=> !run_enable)
    else $error("fault not entered");
  chk_clear_edge: assert property ((op_fault && $stable({local_di, ext_di,
    fb_cmd, key_stop_reset}))[*3] |=> !run_enable) else $error("clear without edge");
  chk_reinit_len: assert property ($fell(reinit_pulse) |->
    rcnt_r == 8'(frc_pkg::REINIT_CYC) && run_enable) else $error("reinit length wrong");
  chk_reinit_gate: assert property ($rose(reinit_pulse) |-> $past(op_fault))
    else $error("reinit outside locked state");
endmodule : frc_props
bind frc_fault_restart frc_props frc_props_inst (.sys_clk, .rstn, .addr, .wdata, .wr,
  .fault_cause, .local_di, .ext_di, .fb_cmd, .key_stop_reset, .op_fault, .fault_relay,
  .run_enable, .reinit_pulse);

// ### tb/frc_operator.sv
`timescale 1ns/1ps
module frc_operator #(
  parameter int HOLD = 8
) (
  // bench requests
  input wire logic  sys_clk,
  input wire logic  press_ok,
  input wire logic  press_clr,
  input wire logic [1:0] sel,
  input wire logic [3:0] idx,
  // panel and inputs
  output logic        key_ok,
  output logic        key_stop_reset,
  output logic [5:0]  local_di,
  output logic [5:0]  ext_di,
  output logic [15:0] fb_cmd
);
  int ok_n = 0;
  int clr_n = 0;
  always @(posedge sys_clk) begin
    if (press_ok) ok_n <= HOLD + 2;
    else if (ok_n > 0) ok_n <= ok_n - 1;
    if (press_clr) clr_n <= 3;
    else if (clr_n > 0) clr_n <= clr_n - 1;
  end
  assign key_ok = ok_n > 0;
  assign key_stop_reset = clr_n > 0 && sel == 2'h0;
  assign local_di = (clr_n > 0 && sel == 2'h1) ? 6'h01 << (idx - 4'h1) : 6'h00;
  assign ext_di = (clr_n > 0 && sel == 2'h2) ? 6'h01 << (idx - 4'h1) : 6'h00;
  assign fb_cmd = (clr_n > 0 && sel == 2'h3) ? 16'h0001 << idx : 16'h0000;
endmodule : frc_operator

// ### tb/frc_fault_restart_tb.sv
`timescale 1ns/1ps
module frc_fault_restart_tb;
  localparam int HOLD = 8;
  logic sys_clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000, rdata, d;
  logic fault_cause = 1'b0, run_permit = 1'b1, io_profile = 1'b0, ext_fitted = 1'b1;
  logic [5:0]  local_di, ext_di;
  logic [15:0] fb_cmd;
  logic key_stop_reset, key_ok, op_fault, fault_relay, run_enable, reinit_pulse, irq;
  logic press_ok = 1'b0, press_clr = 1'b0;
  logic [1:0]  sel = 2'h0;
  logic [3:0]  idx = 4'h0;
  int failures = 0;
  int n_tests = 0;
  always #5 sys_clk = ~sys_clk;
  frc_fault_restart #(.SEC_CYC(27'(10)), .KEY_HOLD_CYC(28'(HOLD))) frc_fault_restart_inst (
    .sys_clk, .rstn, .addr, .wdata, .wr, .rd, .rdata, .fault_cause, .run_permit,
    .io_profile, .ext_fitted, .local_di, .ext_di, .fb_cmd, .key_stop_reset, .key_ok,
    .op_fault, .fault_relay, .run_enable, .reinit_pulse, .irq);
  frc_operator #(.HOLD(HOLD)) frc_operator_inst (.sys_clk, .press_ok, .press_clr, .sel,
    .idx, .key_ok, .key_stop_reset, .local_di, .ext_di, .fb_cmd);
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : cyc
  task automatic wreg(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask : wreg
  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge sys_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1;
    cmp(rdata & m, e);
  endtask : rchk
  task automatic press(input logic [1:0] s, input logic [3:0] i, input logic ok);
    @(posedge sys_clk);
    sel <= s;
    idx <= i;
    press_clr <= !ok;
    press_ok <= ok;
    @(posedge sys_clk);
    press_clr <= 1'b0;
    press_ok <= 1'b0;
    cyc(HOLD + 6);
  endtask : press
  task automatic set_cause(input logic v);
    @(posedge sys_clk);
    fault_cause <= v;
  endtask : set_cause
  task automatic t_reset;
    cmp({op_fault, fault_relay, run_enable, reinit_pulse, irq}, 5'b01100);
    rchk(frc_pkg::ADDR_CTRL, 32'hffff_ffff, 32'h0000_0000);
    rchk(frc_pkg::ADDR_RESTART, 32'hffff_ffff, 32'h0000_0000);
    rchk(8'h20, 32'hffff_ffff, 32'h0000_0000);
    wreg(frc_pkg::ADDR_CTRL, 32'h0000_0003);
    rchk(frc_pkg::ADDR_CTRL, 32'h0000_000f, 32'h0000_0001);
    wreg(frc_pkg::ADDR_CTRL, 32'h0000_0003);
    wreg(frc_pkg::ADDR_CTRL, 32'h0000_000f);
    rchk(frc_pkg::ADDR_CTRL, 32'h0000_000f, 32'h0000_0003);
    wreg(frc_pkg::ADDR_IRQ_EN, 32'h0000_001f);
  endtask : t_reset
  task automatic t_retry;
    int n;
    set_cause(1'b1);
    cyc(2);
    cmp({op_fault, fault_relay, run_enable, irq}, 4'b0101);
    // cause gone before the second attempt, but run refused until the third attempt
    for (n = 2; n < 200 && run_enable !== 1'b1; n++) begin
      @(posedge sys_clk);
      if (n == 20) begin
        fault_cause <= 1'b0;
        run_permit  <= 1'b0;
      end
      if (n == 100) run_permit <= 1'b1;
      #1;
    end
    cmp(32'(n >= 158 && n <= 166), 32'h1);
  endtask : t_retry
  task automatic t_lock;
    wreg(frc_pkg::ADDR_CTRL, 32'h0000_000d);
    set_cause(1'b1);
    cyc(3200);
    rchk(frc_pkg::ADDR_STATUS, 32'h0000_0047, 32'h0000_0002);
    set_cause(1'b0);
    press(2'h0, 4'h0, 1'b0);
    cmp(run_enable, 1'b1);
    wreg(frc_pkg::ADDR_CTRL, 32'h0000_0001);
    set_cause(1'b1);
    cyc(2900);
    cmp(op_fault, 1'b0);
    cyc(200);
    cmp(op_fault, 1'b1);
    set_cause(1'b0);
    press(2'h0, 4'h0, 1'b0);
    rchk(frc_pkg::ADDR_STATUS, 32'h0000_0007, 32'h0000_0003);
    rchk(frc_pkg::ADDR_IRQ_STAT, 32'h0000_0004, 32'h0000_0004);
  endtask : t_lock
  task automatic t_reinit;
    wreg(frc_pkg::ADDR_RESTART, 32'h0000_0001);
    rchk(frc_pkg::ADDR_RESTART, 32'h0000_0001, 32'h0000_0000);
    wreg(frc_pkg::ADDR_CTRL, 32'h0000_1001);
    wreg(frc_pkg::ADDR_RESTART, 32'h0000_0001);
    press(2'h0, 4'h0, 1'b1);
    cmp(reinit_pulse, 1'b1);
    cyc(100);
    cmp(run_enable, 1'b1);
    rchk(frc_pkg::ADDR_RESTART, 32'h0000_0001, 32'h0000_0000);
    rchk(frc_pkg::ADDR_IRQ_STAT, 32'h0000_0010, 32'h0000_0010);
    wreg(frc_pkg::ADDR_IRQ_CLR, 32'h0000_001f);
    cyc(1);
    cmp(irq, 1'b0);
    wreg(frc_pkg::ADDR_CTRL, 32'h0000_1000);
    wreg(frc_pkg::ADDR_RESTART, 32'h0000_0001);
    press(2'h0, 4'h0, 1'b1);
    cmp({reinit_pulse, run_enable}, 2'b01);
    wreg(frc_pkg::ADDR_RESTART, 32'h0000_0000);
  endtask : t_reinit
  task automatic t_manual;
    logic [31:0] ctl [7] = '{32'h0000_0000, 32'h0000_0110, 32'h0000_0120, 32'h0000_0c30,
                             32'h0000_0330, 32'h0000_0330, 32'h0000_0120};
    logic [1:0] sl [7] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h3, 2'h3, 2'h2};
    logic [3:0] ix [7] = '{4'h0, 4'h1, 4'h1, 4'hc, 4'h3, 4'h3, 4'h1};
    logic [6:0] iop    = 7'b010_0000;
    logic [6:0] fit    = 7'b011_1111;
    logic [6:0] run_ok = 7'b010_1111;
    for (int i = 0; i < 7; i++) begin
      wreg(frc_pkg::ADDR_CTRL, ctl[i]);
      io_profile <= iop[i];
      ext_fitted <= fit[i];
      set_cause(1'b1);
      press(sl[i], ix[i], 1'b0);
      cmp(op_fault, 1'b1);
      set_cause(1'b0);
      press(sl[i], ix[i], 1'b0);
      cmp(run_enable, run_ok[i]);
      if (!run_ok[i]) press(2'h0, 4'h0, 1'b0);
    end
  endtask : t_manual
  task automatic end_of_test;
    $display("comparisons %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test
  initial begin
    repeat (2) @(posedge sys_clk);
    rstn <= 1'b1;
    cyc(1);
    t_reset;
    t_retry;
    t_lock;
    t_reinit;
    t_manual;
    end_of_test;
  end
  initial begin
    #200_000;
    failures++;
    end_of_test;
  end
endmodule : frc_fault_restart_tb
